// >>> inc/fce_pkg.sv
// package for the flash check engine: register map, field positions, reset values
`default_nettype none
package fce_pkg;
	// register indices; each register owns one word, so its byte address is four times this
	localparam logic [19:0] ctrl_index     = 20'hf_02f0;
	localparam logic [19:0] result_index   = 20'hf_02f2;
	localparam logic [31:0] ctrl_addr      = {10'h000, ctrl_index, 2'h0};
	localparam logic [31:0] result_addr    = {10'h000, result_index, 2'h0};
	// control field positions
	localparam int          enable_bit     = 7;
	localparam int          range_bit      = 0;
	// reset values
	localparam logic [7:0]  ctrl_reset     = 8'h00;
	localparam logic [15:0] result_reset   = 16'h0000;
	localparam logic [15:0] crc_seed       = 16'h0000;
	// ccitt generator without the x^16 term
	localparam logic [15:0] crc_poly       = 16'h1021;
	// last word index of each range (byte 3ffb / 7ffb sit in these words)
	localparam logic [12:0] last_word_16k  = 13'h0_ffe;
	localparam logic [12:0] last_word_32k  = 13'h1_ffe;
	// engine states
	typedef enum logic [2:0] {
		st_idle = 3'b001,
		st_run  = 3'b010,
		st_done = 3'b100
	} fce_state_e;
endpackage
`default_nettype wire

// >>> rtl/fce_fifo.sv
// small valid/ready fifo built from flip-flops
`default_nettype none
module fce_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,     // clock
	input  wire logic             rst_n,   // async reset, active low
	input  wire logic             clr,     // synchronous flush
	input  wire logic             in_valid, // write request
	output logic                  in_ready, // space available
	input  wire logic [WIDTH-1:0] in_data, // write data
	output logic                  out_valid, // data available
	input  wire logic             out_ready, // read accept
	output logic      [WIDTH-1:0] out_data // head word
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
	logic [AW:0]      cnt_reg, cnt_next;
	logic             push, pop;

	// pointer and count update
	always_comb begin
		push     = in_valid && in_ready;
		pop      = out_valid && out_ready;
		wr_next  = push ? AW'(wr_reg + 1'b1) : wr_reg;
		rd_next  = pop ? AW'(rd_reg + 1'b1) : rd_reg;
		cnt_next = (AW+1)'(cnt_reg + push - pop);
		if (clr) begin
			wr_next  = '0;
			rd_next  = '0;
			cnt_next = '0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_reg  <= '0;
			rd_reg  <= '0;
			cnt_reg <= '0;
		end else begin
			wr_reg  <= wr_next;
			rd_reg  <= rd_next;
			cnt_reg <= cnt_next;
		end
	end

	// storage has no reset; only written words are ever read
	always_ff @(posedge clk) begin
		if (push && !clr) begin
			mem_reg[wr_reg] <= in_data;
		end
	end

	assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
	assign out_valid = (cnt_reg != '0);
	assign out_data  = mem_reg[rd_reg];
endmodule
`default_nettype wire

// >>> rtl/fce_engine.sv
// flash check engine: halt-triggered crc-16-ccitt over code flash, ahb-lite registers
// Contract
// - hold cpu stopped, fetch one 32-bit flash word per clock into crc
// - crc polynomial is x^16 + x^12 + x^5 + 1
// - each word enters msb first, bit 31 down to bit 0
// - control bit 7 enables; run starts on next halt instruction
// - control bit 0 picks range 0000-3ffb or 0000-7ffb
// - control takes bit and byte writes, resets to 00
// - 16-bit result register holds crc, resets to 0000
// - result ignores software writes unless enable bit is 1
// - only code flash is read, never data flash or ram
//
// Design decision made here: register access over AHB-Lite.
`default_nettype none
module fce_engine (
	input  wire logic        hclk,          // system clock, 20 mhz
	input  wire logic        hresetn,       // async reset, active low
	input  wire logic        hsel,          // slave select
	input  wire logic [31:0] haddr,         // byte address
	input  wire logic [1:0]  htrans,        // transfer type
	input  wire logic        hwrite,        // write strobe
	input  wire logic [2:0]  hsize,         // transfer size
	input  wire logic [31:0] hwdata,        // write data
	input  wire logic        hready,        // bus ready in
	output logic      [31:0] hrdata,        // read data
	output logic             hreadyout,     // slave ready
	output logic             hresp,         // always okay
	input  wire logic        halt_request,  // cpu executed halt, one-cycle pulse
	output logic             cpu_stop,      // holds cpu stopped while running
	output logic             halt_release,  // one-cycle pulse ending the halt
	output logic             flash_req,     // code flash read request
	output logic      [12:0] flash_word,    // code flash word index
	input  wire logic        flash_ready,   // flash accepts a request
	input  wire logic        flash_valid,   // flash read data valid
	input  wire logic [31:0] flash_rdata    // flash read data
);
	////////////////////////////////////////////////////////////////////////
	// crc helper
	// one ccitt step per bit, bit 31 first
	function automatic logic [15:0] crc_word(input logic [15:0] c, input logic [31:0] d);
		logic [15:0] r;
		logic        fb;
		r = c;
		for (int i = 31; i >= 0; i--) begin
			fb = r[15] ^ d[i];
			r  = {r[14:0], 1'b0} ^ (fb ? fce_pkg::crc_poly : 16'h0000);
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// bus address phase capture
	logic        ph_wr_reg, ph_wr_next, ph_rd_reg, ph_rd_next;
	logic [31:0] ph_addr_reg, ph_addr_next;
	logic [2:0]  ph_size_reg, ph_size_next;
	logic        take;

	// a two-register slave with zero wait states: the address phase is latched
	always_comb begin
		take         = hsel && hready && htrans[1];
		ph_wr_next   = take && hwrite;
		ph_rd_next   = take && !hwrite;
		ph_addr_next = take ? haddr : ph_addr_reg;
		ph_size_next = take ? hsize : ph_size_reg;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_wr_reg   <= 1'b0;
			ph_rd_reg   <= 1'b0;
			ph_addr_reg <= 32'h0000_0000;
			ph_size_reg <= 3'h0;
		end else begin
			ph_wr_reg   <= ph_wr_next;
			ph_rd_reg   <= ph_rd_next;
			ph_addr_reg <= ph_addr_next;
			ph_size_reg <= ph_size_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registers and engine
	fce_pkg::fce_state_e state_reg, state_next;
	logic [7:0]  ctrl_reg, ctrl_next;
	logic [15:0] result_reg, result_next;
	logic [15:0] crc_reg, crc_next;
	logic [12:0] addr_reg, addr_next;
	logic [12:0] left_reg, left_next;
	logic [31:0] hrdata_reg, hrdata_next;
	logic        rel_reg, rel_next;
	logic        wr_ctrl, wr_res, res_ok;
	logic        fifo_in_ready, fifo_out_valid;
	logic [31:0] fifo_out_data;
	logic        fifo_clr;
	logic [12:0] last_word;

	// flash words pass through the fifo; a full fifo stalls fetching
	fce_fifo #(.WIDTH(32), .DEPTH(8)) u_fifo (
		.clk       (hclk),
		.rst_n     (hresetn),
		.clr       (fifo_clr),
		.in_valid  (flash_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (flash_rdata),
		.out_valid (fifo_out_valid),
		.out_ready (state_reg == fce_pkg::st_run),
		.out_data  (fifo_out_data)
	);

	// control, result, fetch pointer and crc next-state
	always_comb begin
		last_word   = ctrl_reg[fce_pkg::range_bit] ? fce_pkg::last_word_32k
			: fce_pkg::last_word_16k;
		wr_ctrl     = ph_wr_reg && ph_addr_reg == fce_pkg::ctrl_addr;
		// a byte access would tear the 16-bit value, so it never writes the result
		wr_res      = ph_wr_reg && ph_addr_reg == fce_pkg::result_addr
			&& ph_size_reg != 3'h0;
		res_ok      = wr_res && ctrl_reg[fce_pkg::enable_bit];
		state_next  = state_reg;
		ctrl_next   = ctrl_reg;
		result_next = result_reg;
		crc_next    = crc_reg;
		addr_next   = addr_reg;
		left_next   = left_reg;
		rel_next    = 1'b0;
		fifo_clr    = 1'b0;
		// byte write; bit writes arrive as read-modify-write bytes
		if (wr_ctrl) begin
			ctrl_next = hwdata[7:0];
		end
		if (res_ok) begin
			result_next = hwdata[15:0];
		end
		case (state_reg)
			fce_pkg::st_idle: begin
				if (halt_request && ctrl_reg[fce_pkg::enable_bit]) begin
					state_next = fce_pkg::st_run;
					crc_next   = fce_pkg::crc_seed;
					addr_next  = 13'h0_000;
					left_next  = 13'(last_word + 1'b1);
					fifo_clr   = 1'b1;
				end
			end
			fce_pkg::st_run: begin
				if (flash_req && flash_ready) begin
					addr_next = 13'(addr_reg + 1'b1);
				end
				if (fifo_out_valid) begin
					crc_next  = crc_word(crc_reg, fifo_out_data);
					left_next = 13'(left_reg - 1'b1);
					if (left_reg == 13'h0_001) begin
						state_next = fce_pkg::st_done;
					end
				end
			end
			fce_pkg::st_done: begin
				result_next = crc_reg;
				rel_next    = 1'b1;
				state_next  = fce_pkg::st_idle;
			end
			default: state_next = fce_pkg::st_idle;
		endcase
		// read data for the next data phase
		hrdata_next = 32'h0000_0000;
		if (take && !hwrite && haddr == fce_pkg::ctrl_addr) begin
			hrdata_next = {24'h00_0000, ctrl_next};
		end else if (take && !hwrite && haddr == fce_pkg::result_addr) begin
			hrdata_next = {16'h0000, result_next};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg  <= fce_pkg::st_idle;
			ctrl_reg   <= fce_pkg::ctrl_reset;
			result_reg <= fce_pkg::result_reset;
			crc_reg    <= fce_pkg::crc_seed;
			addr_reg   <= 13'h0_000;
			left_reg   <= 13'h0_000;
			hrdata_reg <= 32'h0000_0000;
			rel_reg    <= 1'b0;
		end else begin
			state_reg  <= state_next;
			ctrl_reg   <= ctrl_next;
			result_reg <= result_next;
			crc_reg    <= crc_next;
			addr_reg   <= addr_next;
			left_reg   <= left_next;
			hrdata_reg <= hrdata_next;
			rel_reg    <= rel_next;
		end
	end

	// fetch stops at the range end or while the fifo is full
	assign flash_req    = state_reg == fce_pkg::st_run && fifo_in_ready
		&& addr_reg <= last_word;
	assign flash_word   = addr_reg;
	assign cpu_stop     = state_reg != fce_pkg::st_idle;
	assign halt_release = rel_reg;
	assign hrdata       = hrdata_reg;
	assign hreadyout    = 1'b1;
	assign hresp        = 1'b0;

	////////////////////////////////////////////////////////////////////////
	// checks
	a_result_locked: assert property (@(posedge hclk) disable iff (!hresetn)
		(wr_res && !ctrl_reg[fce_pkg::enable_bit] && state_reg != fce_pkg::st_done)
		|=> $stable(result_reg))
		else $error("result changed while engine disabled");
	a_crc_seed: assert property (@(posedge hclk) disable iff (!hresetn)
		(state_reg == fce_pkg::st_idle && state_next == fce_pkg::st_run)
		|=> crc_reg == 16'h0000)
		else $error("crc not cleared at start");
	a_range_bound: assert property (@(posedge hclk) disable iff (!hresetn)
		flash_req |-> flash_word <= last_word)
		else $error("fetch beyond selected range");
	a_stop_held: assert property (@(posedge hclk) disable iff (!hresetn)
		flash_req |-> cpu_stop)
		else $error("flash fetched while cpu running");
	a_done_result: assert property (@(posedge hclk) disable iff (!hresetn)
		state_reg == fce_pkg::st_done |=> result_reg == $past(crc_reg) && halt_release)
		else $error("result or release missing at end");
	a_no_start_off: assert property (@(posedge hclk) disable iff (!hresetn)
		(state_reg == fce_pkg::st_idle && !ctrl_reg[fce_pkg::enable_bit])
		|=> state_reg == fce_pkg::st_idle)
		else $error("started while disabled");
	a_msb_first: assert property (@(posedge hclk) disable iff (!hresetn)
		(state_reg == fce_pkg::st_run && fifo_out_valid && crc_reg == 16'h0000
		&& fifo_out_data == 32'h8000_0000) |=> crc_reg == 16'hdd38 || state_reg != fce_pkg::st_run)
		else $error("word not shifted msb first");
	a_ctrl_write: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_ctrl |=> ctrl_reg == $past(hwdata[7:0]))
		else $error("control write lost");
endmodule
`default_nettype wire

// >>> verification/fce_flash_model.sv
// code flash array model: one-cycle read latency, stalls on demand
`default_nettype none
module fce_flash_model (
	input  wire logic        hclk,        // system clock
	input  wire logic        hresetn,     // async reset, active low
	input  wire logic        stall,       // bench holds off the flash
	input  wire logic        flash_req,   // read request
	input  wire logic [12:0] flash_word,  // word index
	output logic             flash_ready, // request taken
	output logic             flash_valid, // data valid
	output logic      [31:0] flash_rdata  // read data
);
	timeunit 1ns;
	timeprecision 1ns;
	// slow answers come from refusing requests, never from dropping words
	assign flash_ready = !stall;
	// word content is a pattern of its index; an idle bus shows inverted junk
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flash_valid <= 1'b0;
			flash_rdata <= 32'h0000_0000;
		end else if (flash_req && flash_ready) begin
			flash_valid <= 1'b1;
			flash_rdata <= 32'h8000_0000 ^ {3'h0, flash_word, 3'h0, flash_word};
		end else begin
			flash_valid <= 1'b0;
			flash_rdata <= ~flash_rdata;
		end
	end
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
// self-checking bench for the flash check engine
`default_nettype none
`define CHK(act, exp) begin checks++; if ((act) !== (exp)) begin miscompares++; \
	$display("unexpected t=%0t got %h want %h", $time, act, exp); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h0;
	logic [31:0] hwdata = 32'h0000_0000;
	logic        halt_request = 1'b0;
	logic        stall = 1'b0;
	logic [31:0] hrdata;
	logic        hreadyout, cpu_stop, halt_release, flash_req, flash_ready, flash_valid;
	logic        hresp;
	logic [12:0] flash_word;
	logic [31:0] flash_rdata;
	logic [31:0] rd;
	logic [13:0] exp_idx = 14'h0000;
	int          miscompares = 0;
	int          checks = 0;
	fce_engine i_fce_engine (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .halt_request(halt_request), .cpu_stop(cpu_stop),
		.halt_release(halt_release), .flash_req(flash_req), .flash_word(flash_word),
		.flash_ready(flash_ready), .flash_valid(flash_valid), .flash_rdata(flash_rdata)
	);
	fce_flash_model i_fce_flash_model (
		.hclk(hclk), .hresetn(hresetn), .stall(stall), .flash_req(flash_req),
		.flash_word(flash_word), .flash_ready(flash_ready), .flash_valid(flash_valid),
		.flash_rdata(flash_rdata)
	);
	// 50 ns period
	always #25 hclk = ~hclk;
	// every accepted fetch must be the next ascending word
	always @(posedge hclk) begin
		if (hresetn && flash_req && flash_ready) begin
			`CHK(flash_word, exp_idx[12:0])
			exp_idx = exp_idx + 14'h0001;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// verdict and exit, the only place the run ends
	task automatic end_sim();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic give_up();
		miscompares++;
		$display("unexpected t=%0t wait ran out", $time);
		end_sim();
	endtask
	// one single transfer; waits on hready in both phases, bounded
	task automatic bus(input logic w, input logic [31:0] a, input logic [2:0] sz,
			input logic [31:0] wd, output logic [31:0] q);
		int n;
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= sz;
		n = 0;
		do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 100);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 200);
		q = hrdata;
		`CHK(hresp, 1'b0)
		if (n >= 200) give_up();
	endtask
	task automatic wr_ctrl(input logic [7:0] v);
		bus(1'b1, fce_pkg::ctrl_addr, 3'h2, {24'h00_0000, v}, rd);
	endtask
	task automatic rd_ctrl(input logic [7:0] v);
		bus(1'b0, fce_pkg::ctrl_addr, 3'h2, 32'h0000_0000, rd);
		`CHK(rd[7:0], v)
	endtask
	task automatic wr_res(input logic [15:0] v, input logic [2:0] sz);
		bus(1'b1, fce_pkg::result_addr, sz, {16'h0000, v}, rd);
	endtask
	task automatic rd_res(input logic [15:0] v);
		bus(1'b0, fce_pkg::result_addr, 3'h2, 32'h0000_0000, rd);
		`CHK(rd[15:0], v)
	endtask
	task automatic pulse_halt();
		@(posedge hclk);
		halt_request <= 1'b1;
		@(posedge hclk);
		halt_request <= 1'b0;
	endtask
	// bench's own crc over the model's pattern, zero seed, msb first
	function automatic logic [15:0] crc_of(input logic [13:0] last);
		logic [15:0] c;
		logic [31:0] d;
		c = 16'h0000;
		for (int w = 0; w <= last; w++) begin
			d = 32'h8000_0000 ^ {3'h0, w[12:0], 3'h0, w[12:0]};
			for (int i = 31; i >= 0; i--) begin
				c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
			end
		end
		return c;
	endfunction
	// full run; slow stalls the flash half the time to exercise the fifo
	task automatic run_check(input logic rng, input logic slow, input logic [13:0] last);
		int n;
		exp_idx = 14'h0000;
		wr_ctrl({1'b1, 6'h00, rng});
		pulse_halt();
		n = 0;
		do begin
			@(posedge hclk);
			stall <= slow & n[1];
			n++;
			if (halt_release !== 1'b1) `CHK(cpu_stop, 1'b1)
		end while (halt_release !== 1'b1 && n < 40000);
		if (n >= 40000) give_up();
		stall <= 1'b0;
		@(posedge hclk);
		`CHK(halt_release, 1'b0)
		`CHK(cpu_stop, 1'b0)
		`CHK(exp_idx, last + 14'h0001)
		rd_res(crc_of(last));
		rd_ctrl({1'b1, 6'h00, rng});
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rd_ctrl(8'h00);
		rd_res(16'h0000);
		bus(1'b0, 32'h0000_0100, 3'h2, 32'h0000_0000, rd);
		`CHK(rd, 32'h0000_0000)
	endtask
	task automatic t_locked();
		wr_res(16'h1234, 3'h2);
		rd_res(16'h0000);
		pulse_halt();
		repeat (6) begin
			@(posedge hclk);
			`CHK(cpu_stop, 1'b0)
			`CHK(flash_req, 1'b0)
		end
	endtask
	task automatic t_run16();
		run_check(1'b0, 1'b1, 14'h0ffe);
		bus(1'b1, fce_pkg::result_addr + 32'h0000_0004, 3'h2, 32'h0000_5555, rd);
		rd_res(crc_of(14'h0ffe));
		wr_res(16'hbeef, 3'h2);
		rd_res(16'hbeef);
	endtask
	task automatic t_run32();
		run_check(1'b1, 1'b0, 14'h1ffe);
		wr_ctrl(8'h00);
		wr_res(16'h1111, 3'h2);
		rd_res(crc_of(14'h1ffe));
	endtask
	// reset for 12 cycles, then the scenarios in turn
	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_locked();
		t_run16();
		t_run32();
		end_sim();
	end
endmodule
`default_nettype wire
